/* design/icr_router.sv */
/*
 * Inbound I/O, configuration and memory decode router with APB registers.
 * Requests come from logic on the same clock; one decision per request,
 * given one cycle after the request. APB answers with no wait state.
 */
// Chosen here: register access over APB and the placing of the registers.
module icr_router
#(
    parameter int NUM_PORTS = 4
)
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    input  wire logic [3:0]       pstrb,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    // Inbound request and routing answer
    input  wire icr_pkg::icr_req_t req,
    output icr_pkg::icr_rsp_t     rsp
);
    import icr_pkg::*;

    localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

    // Software state
    logic [31:0] misc_ctrl_q;
    logic [31:0] cfg_en_q;
    logic [31:0] route_ctrl_q;
    logic [31:0] local_io_q;
    logic [31:0] global_io_q;
    logic [31:0] cfg_win_q;
    logic [31:0] int_bus_q;
    logic [31:0] guest_limit_q;
    logic [31:0] remap_base_q;
    logic [31:0] port_io_q  [NUM_PORTS];
    logic [31:0] port_bus_q [NUM_PORTS];
    logic [31:0] req_count_q;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    icr_rsp_t    rsp_q;
    icr_rsp_t    rsp_d;
    icr_rsp_t    last_rsp_q;

    // Control bits
    wire io_en      = misc_ctrl_q[ICR_IO_EN_BIT];
    wire cfg_en     = cfg_en_q[ICR_CFG_EN_BIT];
    wire south_sub  = route_ctrl_q[ICR_SOUTH_SUB_BIT];
    wire sad_disp   = route_ctrl_q[ICR_SAD_DISP_BIT];
    wire p2p_rd_dis = route_ctrl_q[ICR_P2P_RD_DIS_BIT];
    wire remap_en   = route_ctrl_q[ICR_REMAP_EN_BIT];

    // APB decode
    wire        setup    = psel && !penable && !pready_q;
    wire        wr_acc   = psel && penable && pready_q && pwrite;
    wire [11:0] port_rel = paddr - ICR_PORT_BASE_OFS;
    wire [8:0]  port_sel = port_rel[11:3];
    wire        in_ports = (paddr >= ICR_PORT_BASE_OFS) && (port_sel < 9'(NUM_PORTS));
    wire [PW-1:0] pidx   = port_sel[PW-1:0];
    wire        hit_fix  = (paddr <= ICR_REQ_COUNT_OFS) && (paddr[1:0] == 2'b00);
    wire        mapped   = (hit_fix || in_ports) && (paddr[1:0] == 2'b00);
    wire        read_only = (paddr == ICR_LAST_ROUTE_OFS) || (paddr == ICR_REQ_COUNT_OFS);
    wire        bad_acc  = !mapped || (pwrite && read_only);

    // Byte-lane merge of write data
    function automatic logic [31:0] icr_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction : icr_merge

    // Read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (in_ports)
        begin
            rd_mux = port_rel[2] ? port_bus_q[pidx] : port_io_q[pidx];
        end
        else
        begin
            case (paddr)
                ICR_MISC_CTRL_STS_OFS: rd_mux = misc_ctrl_q;
                ICR_CFG_ENABLE_OFS:    rd_mux = cfg_en_q;
                ICR_ROUTE_CTRL_OFS:    rd_mux = route_ctrl_q;
                ICR_LOCAL_IO_OFS:      rd_mux = local_io_q;
                ICR_GLOBAL_IO_OFS:     rd_mux = global_io_q;
                ICR_CFG_BUS_WIN_OFS:   rd_mux = cfg_win_q;
                ICR_INT_BUS_OFS:       rd_mux = int_bus_q;
                ICR_GUEST_LIMIT_OFS:   rd_mux = guest_limit_q;
                ICR_REMAP_BASE_OFS:    rd_mux = remap_base_q;
                ICR_LAST_ROUTE_OFS:    rd_mux = {23'h0, last_rsp_q.cfg_type0, last_rsp_q.port,
                                                 1'b0, last_rsp_q.dest};
                ICR_REQ_COUNT_OFS:     rd_mux = req_count_q;
                default:               rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // APB handshake: answer in the cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            prdata_q  <= (setup && !pwrite && mapped) ? rd_mux : 32'h0000_0000;
            pslverr_q <= setup && bad_acc;
        end
    end

    // Fixed registers, written at the access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            misc_ctrl_q   <= ICR_CTRL_RST;
            cfg_en_q      <= ICR_CTRL_RST;
            route_ctrl_q  <= ICR_CTRL_RST;
            local_io_q    <= ICR_CTRL_RST;
            global_io_q   <= ICR_CTRL_RST;
            cfg_win_q     <= ICR_CTRL_RST;
            int_bus_q     <= ICR_CTRL_RST;
            guest_limit_q <= ICR_GUEST_RST;
            remap_base_q  <= ICR_CTRL_RST;
        end
        else if (wr_acc && !bad_acc && !in_ports)
        begin
            case (paddr)
                ICR_MISC_CTRL_STS_OFS: misc_ctrl_q   <= icr_merge(misc_ctrl_q, pwdata, pstrb); // [R10]
                ICR_CFG_ENABLE_OFS:    cfg_en_q      <= icr_merge(cfg_en_q, pwdata, pstrb);    // [R12]
                ICR_ROUTE_CTRL_OFS:    route_ctrl_q  <= icr_merge(route_ctrl_q, pwdata, pstrb);
                ICR_LOCAL_IO_OFS:      local_io_q    <= icr_merge(local_io_q, pwdata, pstrb);
                ICR_GLOBAL_IO_OFS:     global_io_q   <= icr_merge(global_io_q, pwdata, pstrb);
                ICR_CFG_BUS_WIN_OFS:   cfg_win_q     <= icr_merge(cfg_win_q, pwdata, pstrb);
                ICR_INT_BUS_OFS:       int_bus_q     <= icr_merge(int_bus_q, pwdata, pstrb);
                ICR_GUEST_LIMIT_OFS:   guest_limit_q <= icr_merge(guest_limit_q, pwdata, pstrb);
                ICR_REMAP_BASE_OFS:    remap_base_q  <= icr_merge(remap_base_q, pwdata, pstrb);
                default:               ;
            endcase
        end
    end

    // Per-port window registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_PORTS; i++)
            begin
                port_io_q[i]  <= ICR_CTRL_RST;
                port_bus_q[i] <= ICR_CTRL_RST;
            end
        end
        else if (wr_acc && in_ports && !bad_acc)
        begin
            if (port_rel[2])
            begin
                port_bus_q[pidx] <= icr_merge(port_bus_q[pidx], pwdata, pstrb);
            end
            else
            begin
                port_io_q[pidx] <= icr_merge(port_io_q[pidx], pwdata, pstrb);
            end
        end
    end

    // Request classification
    wire [15:0] a16       = req.addr[15:0];
    wire        io_hi     = (req.addr[31:16] != 16'h0000);
    wire        disp_io   = !io_hi &&
                            (((a16 >= ICR_DISP_IO_A_LO) && (a16 <= ICR_DISP_IO_A_HI)) ||
                             ((a16 >= ICR_DISP_IO_B_LO) && (a16 <= ICR_DISP_IO_B_HI)));
    wire        lio_hit   = !io_hi && (a16 >= local_io_q[15:0]) && (a16 <= local_io_q[31:16]);
    wire        gio_hit   = !io_hi && (a16 >= global_io_q[15:0]) && (a16 <= global_io_q[31:16]);
    wire [7:0]  bus       = req.bus;
    wire        lbus_hit  = (bus >= cfg_win_q[7:0]) && (bus <= cfg_win_q[15:8]);
    wire        gbus_hit  = (bus >= cfg_win_q[23:16]) && (bus <= cfg_win_q[31:24]);
    wire        disp_mem  = (req.addr >= ICR_DISP_MEM_LO) && (req.addr <= ICR_DISP_MEM_HI);
    wire        remap_hit = (req.addr[31:12] == remap_base_q[31:12]) && remap_base_q[0];
    wire [5:0]  gwidth    = guest_limit_q[5:0];
    wire        guest_over = (gwidth < 6'd32) && ((req.addr >> gwidth) != 32'h0000_0000);

    // Per-port matches
    logic [NUM_PORTS-1:0] dre_vec;
    logic [NUM_PORTS-1:0] pio_vec;
    logic [NUM_PORTS-1:0] pbus_vec;
    for (genvar g = 0; g < NUM_PORTS; g++)
    begin : g_port
        assign dre_vec[g]  = port_bus_q[g][ICR_DISP_ROUTE_BIT];
        assign pio_vec[g]  = !io_hi && (a16 >= port_io_q[g][15:0]) &&
                             (a16 <= port_io_q[g][31:16]);
        assign pbus_vec[g] = (bus >= port_bus_q[g][7:0]) && (bus <= port_bus_q[g][15:8]);
    end

    // Lowest matching port
    function automatic logic [3:0] icr_first(input logic [NUM_PORTS-1:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NUM_PORTS - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction : icr_first

    wire [3:0]  dre_port  = icr_first(dre_vec);
    wire [3:0]  pio_port  = icr_first(pio_vec);
    wire [3:0]  pbus_port = icr_first(pbus_vec);
    wire [7:0]  sec_bus   = port_bus_q[pbus_port[PW-1:0]][7:0];
    wire icr_dest_t south_or_ma = south_sub ? ICR_DST_SOUTH : ICR_DST_MABORT;
    wire icr_dest_t subtractive = south_sub ? ICR_DST_SOUTH : ICR_DST_FABRIC;

    // Routing decision; remap state is not consulted for I/O or config [R18]
    always_comb
    begin
        rsp_d           = '0;
        rsp_d.valid     = req.valid;
        case (req.kind)
            ICR_KIND_IO:
            begin
                if (!io_en)
                    rsp_d.dest = ICR_DST_MABORT;                     // [R1] [R10]
                else if (disp_io)
                begin
                    if (sad_disp || (!lio_hit && gio_hit))
                        rsp_d.dest = ICR_DST_FABRIC;                 // [R2]
                    else if (|dre_vec)
                    begin
                        rsp_d.dest = ICR_DST_PORT;                   // [R3]
                        rsp_d.port = dre_port;
                    end
                    else if (|pio_vec)
                    begin
                        rsp_d.dest = ICR_DST_PORT;                   // [R4]
                        rsp_d.port = pio_port;
                    end
                    else
                        rsp_d.dest = south_or_ma;                    // [R5]
                end
                else if (lio_hit)
                begin
                    if (|pio_vec)
                    begin
                        rsp_d.dest = ICR_DST_PORT;                   // [R6]
                        rsp_d.port = pio_port;
                    end
                    else
                        rsp_d.dest = south_or_ma;                    // [R7]
                end
                else if (gio_hit)
                    rsp_d.dest = ICR_DST_FABRIC;                     // [R8]
                else if (io_hi)
                    rsp_d.dest = ICR_DST_MABORT;                     // [R9]
                else
                    rsp_d.dest = subtractive;                        // [R9]
            end
            ICR_KIND_CFG:
            begin
                if (!req.type1)
                    rsp_d.dest = ICR_DST_MABORT;                     // [R11]
                else if (!cfg_en || (bus == 8'h00))
                    rsp_d.dest = ICR_DST_MABORT;                     // [R12]
                else if (bus == int_bus_q[7:0])
                    rsp_d.dest = ICR_DST_MABORT;                     // [R13]
                else if (lbus_hit)
                begin
                    if (|pbus_vec)
                    begin
                        rsp_d.dest      = ICR_DST_PORT;              // [R16]
                        rsp_d.port      = pbus_port;
                        rsp_d.cfg_type0 = (bus == sec_bus);
                    end
                    else
                        rsp_d.dest = south_or_ma;                    // [R17]
                end
                else if (gbus_hit)
                    rsp_d.dest = ICR_DST_FABRIC;                     // [R14]
                else
                    rsp_d.dest = subtractive;                        // [R15]
            end
            ICR_KIND_MEM:
            begin
                if (remap_hit)
                    rsp_d.dest = ICR_DST_CABORT;                     // [R22] [R21]
                else if (remap_en && guest_over)
                    rsp_d.dest = ICR_DST_MABORT;                     // [R20]
                else if (disp_mem)
                begin
                    if (req.from_dma)
                        rsp_d.dest = ICR_DST_CABORT;                 // [R23]
                    else if (req.is_read && p2p_rd_dis)
                        rsp_d.dest = ICR_DST_MABORT;                 // [R24]
                    else if (sad_disp)
                        rsp_d.dest = ICR_DST_FABRIC;                 // [R19]
                    else if (req.is_read)
                        rsp_d.dest = ICR_DST_MABORT;                 // [R25]
                    else if (|dre_vec)
                    begin
                        rsp_d.dest = ICR_DST_PORT;                   // [R25]
                        rsp_d.port = dre_port;
                    end
                    else
                        rsp_d.dest = south_or_ma;
                end
                else
                    rsp_d.dest = ICR_DST_FABRIC;                     // [R19]
            end
            default:
                rsp_d.dest = ICR_DST_FABRIC;                         // [R18]
        endcase
        if (!req.valid)
        begin
            rsp_d = '0;
        end
    end

    // Decision register, last decision held for software, counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rsp_q       <= '0;
            last_rsp_q  <= '0;
            req_count_q <= 32'h0000_0000;
        end
        else
        begin
            rsp_q <= rsp_d;
            if (req.valid)
            begin
                last_rsp_q  <= rsp_d;
                req_count_q <= req_count_q + 32'h0000_0001;
            end
        end
    end

    // Outputs from flops
    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;
    assign rsp     = rsp_q;

endmodule : icr_router

/* design/icr_pkg.sv */
/*
 * Package of the inbound I/O and configuration decode router: register
 * offsets, field positions, reset values, request and answer carriers.
 * Assumes a single core clock and an APB register port with 32-bit data.
 */
// Behaviour
// R1: Inbound I/O disabled: master abort all I/O
// R2: Display I/O to fabric on decoder or global-only
// R3: Display I/O to port with display route enable
// R4: Else display I/O to port I/O window hit
// R5: Else south link if subtractive, else abort
// R6: Local I/O window hit on port: forward there
// R7: Local window, no port: south link or abort
// R8: Outside local, inside global I/O: fabric
// R9: I/O at or above 64 KB aborted; rest subtractive
// R10: Misc control bit 30 enables inbound I/O
// R11: Inbound type 0 configuration always master aborted
// R12: Config enable bit 1; off or bus 0 aborts
// R13: Bus equal to internal bus number aborted
// R14: Outside local, inside global bus window: fabric
// R15: Outside global bus window: subtractive decode port
// R16: Local bus hit on port: forward, type by secondary
// R17: Local bus, no port: south link or abort
// R18: Remapping leaves I/O and configuration decode untouched
// R19: Translated addresses get the normal memory checks
// R20: Guest addresses bounded by guest address limit
// R21: Remap window reached only outbound, aligned accesses
// R22: Inbound access to remap window completer aborted
// R23: DMA agent accesses to display memory aborted
// R24: Peer read disable aborts peer memory reads
// R25: Peer writes supported, peer reads not
package icr_pkg;

    // Register byte offsets
    localparam logic [11:0] ICR_MISC_CTRL_STS_OFS = 12'h000;
    localparam logic [11:0] ICR_CFG_ENABLE_OFS    = 12'h004;
    localparam logic [11:0] ICR_ROUTE_CTRL_OFS    = 12'h008;
    localparam logic [11:0] ICR_LOCAL_IO_OFS      = 12'h00c;
    localparam logic [11:0] ICR_GLOBAL_IO_OFS     = 12'h010;
    localparam logic [11:0] ICR_CFG_BUS_WIN_OFS   = 12'h014;
    localparam logic [11:0] ICR_INT_BUS_OFS       = 12'h018;
    localparam logic [11:0] ICR_GUEST_LIMIT_OFS   = 12'h01c;
    localparam logic [11:0] ICR_REMAP_BASE_OFS    = 12'h020;
    localparam logic [11:0] ICR_LAST_ROUTE_OFS    = 12'h024;
    localparam logic [11:0] ICR_REQ_COUNT_OFS     = 12'h028;
    localparam logic [11:0] ICR_PORT_BASE_OFS     = 12'h040;

    // Field positions
    localparam int ICR_IO_EN_BIT       = 30;
    localparam int ICR_CFG_EN_BIT      = 1;
    localparam int ICR_SOUTH_SUB_BIT   = 0;
    localparam int ICR_SAD_DISP_BIT    = 1;
    localparam int ICR_P2P_RD_DIS_BIT  = 2;
    localparam int ICR_REMAP_EN_BIT    = 3;
    localparam int ICR_DISP_ROUTE_BIT  = 16;

    // Reset values
    localparam logic [31:0] ICR_CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] ICR_GUEST_RST    = 32'h0000_0020;

    // Fixed legacy ranges
    localparam logic [15:0] ICR_DISP_IO_A_LO = 16'h03b0;
    localparam logic [15:0] ICR_DISP_IO_A_HI = 16'h03bb;
    localparam logic [15:0] ICR_DISP_IO_B_LO = 16'h03c0;
    localparam logic [15:0] ICR_DISP_IO_B_HI = 16'h03df;
    localparam logic [31:0] ICR_DISP_MEM_LO  = 32'h000a_0000;
    localparam logic [31:0] ICR_DISP_MEM_HI  = 32'h000b_ffff;

    typedef enum logic [1:0] {ICR_KIND_IO, ICR_KIND_CFG, ICR_KIND_MEM, ICR_KIND_MSG} icr_kind_t;

    typedef enum logic [2:0] {ICR_DST_NONE, ICR_DST_FABRIC, ICR_DST_PORT, ICR_DST_SOUTH,
                              ICR_DST_MABORT, ICR_DST_CABORT} icr_dest_t;

    // Inbound request from a port
    typedef struct packed {
        logic       valid;
        icr_kind_t  kind;
        logic       is_read;
        logic       from_dma;
        logic       type1;
        logic [7:0] bus;
        logic [31:0] addr;
    } icr_req_t;

    // Routing decision
    typedef struct packed {
        logic       valid;
        icr_dest_t  dest;
        logic [3:0] port;
        logic       cfg_type0;
    } icr_rsp_t;

endpackage : icr_pkg

/* dv/icr_router_checker.sv */
/* Timing and fixed-outcome checks on the router's ports.
   Assumes binding to icr_router; one clock, async low reset. */
module icr_router_checker
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // Requests and answers
    input wire icr_pkg::icr_req_t req,
    input wire icr_pkg::icr_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import icr_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Answer timing
    a_rsp_follows: assert property (req.valid |=> rsp.valid)
        else $error("answer missing one cycle after request");
    a_rsp_no_spur: assert property (!req.valid |=> !rsp.valid)
        else $error("answer without request");
    a_rsp_idle_zero: assert property (!rsp.valid |-> rsp == '0)
        else $error("answer fields not zero while idle");
    // Fixed outcomes
    a_cfg0_abort: assert property (req.valid && req.kind == ICR_KIND_CFG && !req.type1
        |=> rsp.dest == ICR_DST_MABORT) else $error("type 0 config not aborted");
    a_bus0_abort: assert property (req.valid && req.kind == ICR_KIND_CFG
        && req.type1 && req.bus == 8'h00 |=> rsp.dest == ICR_DST_MABORT)
        else $error("bus 0 config not aborted");
    a_io_high_abort: assert property (req.valid && req.kind == ICR_KIND_IO
        && req.addr[31:16] != 16'h0000 |=> rsp.dest == ICR_DST_MABORT)
        else $error("I/O above 64 KB not aborted");
    a_msg_fabric: assert property (req.valid && req.kind == ICR_KIND_MSG
        |=> rsp.dest == ICR_DST_FABRIC) else $error("message not sent to fabric");
    // APB handshake
    a_apb_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single pulse after setup");
    a_apb_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data or error outside ready");

    c_cfg_port: cover property (req.valid && req.kind == ICR_KIND_CFG
        ##1 rsp.dest == ICR_DST_PORT);
    c_apb_err: cover property (pready && pslverr);
    c_cabort: cover property (rsp.dest == ICR_DST_CABORT);
endmodule : icr_router_checker

/* dv/icr_port_model.sv */
/* Inbound port model: launches one request per call.
   Assumes the router takes req at the rising edge of pclk. */
module icr_port_model
(
    // Clock
    input wire logic          pclk,
    // Request toward the router
    output icr_pkg::icr_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    import icr_pkg::*;
    logic [31:0] idle_q = 32'h5a5a_5a5a;

    initial req = '0;
    // Drive one request, then release with a changing pattern
    task send(input icr_kind_t k, input logic rd, input logic dma, input logic t1,
              input logic [7:0] b, input logic [31:0] a);
        @(posedge pclk);
        req <= {1'b1, k, rd, dma, t1, b, a};
        @(posedge pclk);
        idle_q <= ~idle_q;
        req <= {1'b0, 2'h3, 3'h5, idle_q[7:0], idle_q};
    endtask : send
endmodule : icr_port_model

/* dv/tb_icr_router.sv */
/* Self-checking bench for the router: APB set-up, request table.
   Assumes icr_router, icr_port_model and the checker are compiled. */
module tb_icr_router;
    timeunit 1ns;
    timeprecision 1ps;
    import icr_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd_d;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, err_d;
    icr_req_t    req;
    icr_rsp_t    rsp, ex_d;
    icr_rsp_t    exp_q[$];
    int          mismatches = 0, n_compared = 0, cyc = 0;

    always #20 pclk = ~pclk;
    icr_port_model pm (.pclk(pclk), .req(req));
    icr_router dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .req(req), .rsp(rsp));

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // One APB transfer, held until ready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_d = prdata;
        err_d = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // Note the expected answer, then launch
    task rq(input icr_kind_t k, input logic rd, input logic dma, input logic t1,
            input logic [7:0] b, input logic [31:0] a, input icr_dest_t d,
            input logic [3:0] p, input logic t0);
        exp_q.push_back({1'b1, d, p, t0});
        pm.send(k, rd, dma, t1, b, a);
    endtask : rq
    task io(input logic [31:0] a, input icr_dest_t d, input logic [3:0] p);
        rq(ICR_KIND_IO, 1'b0, 1'b0, 1'b0, 8'h00, a, d, p, 1'b0);
    endtask : io
    task cf(input logic t1, input logic [7:0] b, input icr_dest_t d, input logic t0);
        rq(ICR_KIND_CFG, 1'b0, 1'b0, t1, b, 32'h0, d, (d == ICR_DST_PORT) ? 4'h0 : 4'h0, t0);
    endtask : cf
    task mem(input logic rd, input logic dma, input logic [31:0] a, input icr_dest_t d);
        rq(ICR_KIND_MEM, rd, dma, 1'b0, 8'h00, a, d, (d == ICR_DST_PORT) ? 4'h1 : 4'h0, 1'b0);
    endtask : mem

    // Answer watcher: oldest note against each answer
    always @(negedge pclk)
        if (rsp.valid === 1'b1)
        begin
            ex_d = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            cmp({23'h0, rsp}, {23'h0, ex_d});
        end
    // Hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            close_out();
        end
    end

    initial
    begin
        void'($urandom(32'h33d9fd9f));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ICR_GUEST_LIMIT_OFS, 32'h0);
        cmp(rd_d, ICR_GUEST_RST);
        apb(1'b0, ICR_MISC_CTRL_STS_OFS, 32'h0);
        cmp(rd_d, ICR_CTRL_RST);
        apb(1'b0, 12'h030, 32'h0);
        cmp({31'h0, err_d}, 32'h1);
        wr(ICR_REQ_COUNT_OFS, 32'hffff_ffff);
        cmp({31'h0, err_d}, 32'h1);
        io(32'h0000_03c0, ICR_DST_MABORT, 4'h0);
        io(32'h0000_1010, ICR_DST_MABORT, 4'h0);
        wr(ICR_LOCAL_IO_OFS, 32'h1fff_1000);
        wr(ICR_GLOBAL_IO_OFS, 32'h2fff_1000);
        wr(ICR_CFG_BUS_WIN_OFS, 32'h1f02_0902);
        wr(ICR_INT_BUS_OFS, 32'h0000_0005);
        wr(ICR_PORT_BASE_OFS, 32'h10ff_1000);
        wr(12'h044, 32'h0000_0302);
        wr(12'h04c, 32'h0001_0000);
        wr(12'h050, 32'h03ff_03c0);
        wr(ICR_MISC_CTRL_STS_OFS, 32'h4000_0000);
        wr(ICR_CFG_ENABLE_OFS, 32'h0000_0002);
        wr(ICR_ROUTE_CTRL_OFS, 32'h0000_0001);
        repeat (4) io(32'h1000 + ($urandom % 256), ICR_DST_PORT, 4'h0);
        io(32'h0000_1800, ICR_DST_SOUTH, 4'h0);
        io(32'h0000_2800, ICR_DST_FABRIC, 4'h0);
        io(32'h0001_0000, ICR_DST_MABORT, 4'h0);
        io(32'h0000_0500, ICR_DST_SOUTH, 4'h0);
        io(32'h0000_03c0, ICR_DST_PORT, 4'h1);
        mem(1'b0, 1'b0, ICR_DISP_MEM_LO, ICR_DST_PORT);
        mem(1'b1, 1'b0, ICR_DISP_MEM_LO, ICR_DST_MABORT);
        mem(1'b0, 1'b1, ICR_DISP_MEM_HI, ICR_DST_CABORT);
        wr(ICR_ROUTE_CTRL_OFS, 32'h0000_0002);
        io(32'h0000_03b0, ICR_DST_FABRIC, 4'h0);
        wr(ICR_ROUTE_CTRL_OFS, 32'h0000_0006);
        mem(1'b1, 1'b0, ICR_DISP_MEM_LO, ICR_DST_MABORT);
        wr(12'h04c, 32'h0000_0000);
        wr(ICR_ROUTE_CTRL_OFS, 32'h0000_0001);
        io(32'h0000_03c5, ICR_DST_PORT, 4'h2);
        io(32'h0000_03b5, ICR_DST_SOUTH, 4'h0);
        cf(1'b0, 8'h02, ICR_DST_MABORT, 1'b0);
        cf(1'b1, 8'h00, ICR_DST_MABORT, 1'b0);
        cf(1'b1, 8'h05, ICR_DST_MABORT, 1'b0);
        cf(1'b1, 8'h02, ICR_DST_PORT, 1'b1);
        cf(1'b1, 8'h03, ICR_DST_PORT, 1'b0);
        cf(1'b1, 8'h08, ICR_DST_SOUTH, 1'b0);
        cf(1'b1, 8'h10, ICR_DST_FABRIC, 1'b0);
        cf(1'b1, 8'h40, ICR_DST_SOUTH, 1'b0);
        wr(ICR_ROUTE_CTRL_OFS, 32'h0000_0000);
        io(32'h0000_03b5, ICR_DST_MABORT, 4'h0);
        io(32'h0000_1800, ICR_DST_MABORT, 4'h0);
        io(32'h0000_0500, ICR_DST_FABRIC, 4'h0);
        cf(1'b1, 8'h08, ICR_DST_MABORT, 1'b0);
        cf(1'b1, 8'h40, ICR_DST_FABRIC, 1'b0);
        wr(ICR_ROUTE_CTRL_OFS, 32'h0000_0008);
        wr(ICR_GUEST_LIMIT_OFS, 32'h0000_0014);
        wr(ICR_REMAP_BASE_OFS, 32'h8000_0001);
        io(32'h0000_1010, ICR_DST_PORT, 4'h0);
        cf(1'b1, 8'h02, ICR_DST_PORT, 1'b1);
        rq(ICR_KIND_MSG, 1'b0, 1'b0, 1'b0, 8'h00, 32'h0, ICR_DST_FABRIC, 4'h0, 1'b0);
        mem(1'b0, 1'b0, 32'h8000_0040, ICR_DST_CABORT);
        mem(1'b0, 1'b0, 32'h0010_0000, ICR_DST_MABORT);
        mem(1'b0, 1'b0, 32'h000f_0000, ICR_DST_FABRIC);
        apb(1'b0, ICR_LAST_ROUTE_OFS, 32'h0);
        cmp(rd_d, 32'h0000_0001);
        apb(1'b0, ICR_REQ_COUNT_OFS, 32'h0);
        cmp(rd_d, 32'h0000_0025);
        wr(ICR_CFG_ENABLE_OFS, 32'h0000_0000);
        cf(1'b1, 8'h02, ICR_DST_MABORT, 1'b0);
        wr(ICR_MISC_CTRL_STS_OFS, 32'h0000_0000);
        io(32'h0000_1010, ICR_DST_MABORT, 4'h0);
        repeat (4) @(posedge pclk);
        cmp(exp_q.size(), 32'h0);
        close_out();
    end
endmodule : tb_icr_router

bind icr_router icr_router_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .req(req), .rsp(rsp));
